//--- rtl/emfb_bus.sv
// Purpose: program fetch and external data bus of the core
// Assumes: core requests on clock_i; internal rom answers same cycle
// Notes:   pins are registered; port zero read through a synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "emfb_cfg.svh"
module emfb_bus #(
	parameter int unsigned ROM_KB = 4
) (
	// clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_i,
	// core request and answer
	input  wire emfb_pkg::emfb_req_t  req_i,
	output logic                      req_ready_o,
	output emfb_pkg::emfb_rsp_t       rsp_o,
	output logic [15:0]               pc_o,
	// port two as general i/o
	input  wire emfb_pkg::emfb_gpio_t gpio_two_i,
	// internal program rom
	output logic [15:0]               int_rom_addr_o,
	output logic                      int_rom_rd_o,
	input  wire logic [7:0]           int_rom_data_i,
	// pins
	input  wire logic                 external_access_strap_n_i,
	input  wire logic [7:0]           port_zero_i,
	output logic [7:0]                port_zero_o,
	output logic                      port_zero_oe_n_o,
	output logic [7:0]                port_two_o,
	output logic                      port_two_oe_n_o,
	output logic                      addr_latch_o,
	output logic                      program_store_strobe_n_o,
	output logic                      data_read_strobe_n_o,
	output logic                      data_write_strobe_n_o
);
	import emfb_pkg::*;

	emfb_state_t state_reg;
	emfb_state_t state_next;
	emfb_op_t    op_reg;
	emfb_op_t    op_next;
	logic [15:0] pc_reg;
	logic [15:0] pc_next;
	logic [15:0] bus_addr_reg;
	logic [15:0] bus_addr_next;
	logic        wide_reg;
	logic        wide_next;
	logic [7:0]  wdata_reg;
	logic [7:0]  wdata_next;
	logic [2:0]  cnt_reg;
	logic [2:0]  cnt_next;
	logic [1:0]  settle_reg;
	logic        strap_high;
	logic [7:0]  port_zero_sync;
	logic        accept;
	logic        route_int;
	logic [15:0] route_addr;
	logic [15:0] vec_entry;
	logic        is_fetch_next;
	logic        hi_on_two_next;

	// strap resets to high so that nothing leaks out before it settles
	emfb_sync #(
		.W         (1),
		.RESET_VAL (1'b1)
	) u_strap_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.async_i (external_access_strap_n_i),
		.sync_o  (strap_high)
	);

	emfb_sync #(
		.W         (8),
		.RESET_VAL (8'h00)
	) u_p0_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.async_i (port_zero_i),
		.sync_o  (port_zero_sync)
	);

	emfb_route #(
		.ROM_KB (ROM_KB)
	) u_route (
		.addr_i       (route_addr),
		.strap_high_i (strap_high),
		.internal_o   (route_int)
	);

	assign accept     = req_i.valid && req_ready_o;
	assign route_addr = (req_i.op == EMFB_OP_FETCH) ? pc_reg : req_i.addr;
	assign vec_entry  = `EMFB_VEC_BASE +
		{10'h000, req_i.addr[2:0], 3'h0};

	// sequencing of one access
	always_comb begin
		state_next    = state_reg;
		op_next       = op_reg;
		pc_next       = pc_reg;
		bus_addr_next = bus_addr_reg;
		wide_next     = wide_reg;
		wdata_next    = wdata_reg;
		cnt_next      = cnt_reg;
		case (state_reg)
			EMFB_ST_IDLE: begin
				if (accept) begin
					op_next    = req_i.op;
					wide_next  = req_i.wide;
					wdata_next = req_i.wdata;
					case (req_i.op)
						EMFB_OP_FETCH, EMFB_OP_CODE_RD: begin
							// only reads of code exist; no write path
							bus_addr_next = route_addr;
							if (req_i.op == EMFB_OP_FETCH) begin
								pc_next = pc_reg + 16'h0001;
							end
							state_next = route_int ? EMFB_ST_INT
								: EMFB_ST_ADDR;
							cnt_next = `EMFB_ADDR_CYC - 3'h1;
						end
						EMFB_OP_JUMP: begin
							pc_next    = req_i.addr;
							state_next = EMFB_ST_END;
						end
						EMFB_OP_VECTOR: begin
							pc_next    = vec_entry;
							state_next = EMFB_ST_END;
						end
						EMFB_OP_DATA_RD, EMFB_OP_DATA_WR: begin
							// narrow address from a pointer register
							bus_addr_next = req_i.wide ? req_i.addr
								: {8'h00, req_i.addr[7:0]};
							state_next = EMFB_ST_ADDR;
							cnt_next   = `EMFB_ADDR_CYC - 3'h1;
						end
						default: state_next = EMFB_ST_IDLE;
					endcase
				end
			end
			EMFB_ST_INT: state_next = EMFB_ST_IDLE;
			EMFB_ST_ADDR: begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0) state_next = EMFB_ST_HOLD;
			end
			EMFB_ST_HOLD: begin
				state_next = EMFB_ST_STROBE;
				cnt_next   = `EMFB_STROBE_CYC - 3'h1;
			end
			EMFB_ST_STROBE: begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0) state_next = EMFB_ST_END;
			end
			EMFB_ST_END: state_next = EMFB_ST_IDLE;
			default: state_next = EMFB_ST_IDLE;
		endcase
	end

	assign is_fetch_next  = (op_next == EMFB_OP_FETCH)
		|| (op_next == EMFB_OP_CODE_RD);
	assign hi_on_two_next = is_fetch_next || wide_next;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg    <= EMFB_ST_IDLE;
			op_reg       <= EMFB_OP_FETCH;
			bus_addr_reg <= 16'h0000;
			wide_reg     <= 1'b0;
			wdata_reg    <= 8'h00;
			cnt_reg      <= 3'h0;
		end else begin
			state_reg    <= state_next;
			op_reg       <= op_next;
			bus_addr_reg <= bus_addr_next;
			wide_reg     <= wide_next;
			wdata_reg    <= wdata_next;
			cnt_reg      <= cnt_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pc_reg <= `EMFB_RESET_PC;
		end else begin
			pc_reg <= pc_next;
		end
	end
	assign pc_o = pc_reg;

	// requests wait until the strap has passed the synchroniser
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			settle_reg  <= 2'h0;
			req_ready_o <= 1'b0;
		end else begin
			if (settle_reg != `EMFB_SETTLE_CYC) begin
				settle_reg <= settle_reg + 2'h1;
			end
			req_ready_o <= (state_next == EMFB_ST_IDLE)
				&& (settle_reg == `EMFB_SETTLE_CYC);
		end
	end

	// answers: internal rom same cycle, external data taken at the last strobe cycle and valid in the end cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rsp_o          <= '0;
			int_rom_addr_o <= 16'h0000;
			int_rom_rd_o   <= 1'b0;
		end else begin
			rsp_o.valid    <= 1'b0;
			int_rom_rd_o   <= (state_next == EMFB_ST_INT);
			int_rom_addr_o <= bus_addr_next;
			if (state_reg == EMFB_ST_INT) begin
				rsp_o.valid    <= 1'b1;
				rsp_o.internal <= 1'b1;
				rsp_o.data     <= int_rom_data_i;
			end else if (state_reg == EMFB_ST_STROBE && cnt_reg == 3'h0) begin
				// two sync stages still leave two strobe cycles of settling
				rsp_o.internal <= 1'b0;
				rsp_o.data     <= (op_reg == EMFB_OP_DATA_WR) ? 8'h00
					: port_zero_sync;
			end else if (state_reg == EMFB_ST_END) begin
				rsp_o.valid <= 1'b1;
				if (op_reg == EMFB_OP_JUMP || op_reg == EMFB_OP_VECTOR) begin
					rsp_o.internal <= 1'b1;
					rsp_o.data     <= 8'h00;
				end
			end
		end
	end

	// port zero: address, then float for reads or data for writes
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			port_zero_o      <= 8'h00;
			port_zero_oe_n_o <= 1'b1;
			addr_latch_o     <= 1'b0;
		end else begin
			addr_latch_o     <= (state_next == EMFB_ST_ADDR);
			port_zero_oe_n_o <= 1'b1;
			port_zero_o      <= 8'h00;
			case (state_next)
				EMFB_ST_ADDR, EMFB_ST_HOLD: begin
					port_zero_oe_n_o <= 1'b0;
					port_zero_o      <= bus_addr_next[7:0];
				end
				EMFB_ST_STROBE, EMFB_ST_END: begin
					if (op_next == EMFB_OP_DATA_WR) begin
						port_zero_oe_n_o <= 1'b0;
						port_zero_o      <= wdata_next;
					end
				end
				default: port_zero_oe_n_o <= 1'b1;
			endcase
		end
	end

	// port two: high byte for code and wide data, else general i/o
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			port_two_o      <= 8'h00;
			port_two_oe_n_o <= 1'b1;
		end else if (state_next != EMFB_ST_IDLE
			&& state_next != EMFB_ST_INT
			&& hi_on_two_next
			&& !(state_next == EMFB_ST_END
			&& (op_next == EMFB_OP_JUMP || op_next == EMFB_OP_VECTOR))) begin
			port_two_o      <= bus_addr_next[15:8];
			port_two_oe_n_o <= 1'b0;
		end else begin
			port_two_o      <= gpio_two_i.value;
			port_two_oe_n_o <= gpio_two_i.drive_n;
		end
	end

	// strobes idle high, low only during the strobe phase of their access
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			program_store_strobe_n_o <= `EMFB_STROBE_IDLE;
			data_read_strobe_n_o     <= `EMFB_STROBE_IDLE;
			data_write_strobe_n_o    <= `EMFB_STROBE_IDLE;
		end else begin
			program_store_strobe_n_o <= !(state_next == EMFB_ST_STROBE
				&& is_fetch_next);
			data_read_strobe_n_o <= !(state_next == EMFB_ST_STROBE
				&& op_next == EMFB_OP_DATA_RD);
			data_write_strobe_n_o <= !(state_next == EMFB_ST_STROBE
				&& op_next == EMFB_OP_DATA_WR);
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	reset_pc_a: assert property ($past(rst_i) |-> pc_reg == 16'h0000)
		else $error("pc not at zero after reset");
	vector_entry_a: assert property (
		accept && req_i.op == EMFB_OP_VECTOR && req_i.addr[2:0] == 3'h1
		|=> pc_reg == 16'h000b)
		else $error("timer entry not at 000b");
	strap_low_a: assert property (accept && !strap_high
		&& req_i.op == EMFB_OP_FETCH |=> state_reg == EMFB_ST_ADDR)
		else $error("fetch stayed internal with strap low");
	int_no_strobe_a: assert property (
		state_reg == EMFB_ST_INT |-> program_store_strobe_n_o ##1
		program_store_strobe_n_o)
		else $error("program strobe during internal fetch");
	ext_strobe_a: assert property (accept && !route_int
		&& req_i.op == EMFB_OP_FETCH |-> ##[4:5] !program_store_strobe_n_o)
		else $error("external fetch without program strobe");
	float_read_a: assert property (
		!program_store_strobe_n_o || !data_read_strobe_n_o
		|-> port_zero_oe_n_o)
		else $error("port zero driven while memory answers");
	latch_addr_a: assert property (addr_latch_o |-> !port_zero_oe_n_o
		&& port_zero_o == bus_addr_reg[7:0] ##1 !port_zero_oe_n_o)
		else $error("address not valid around latch strobe");
	high_byte_a: assert property (!program_store_strobe_n_o
		|-> !port_two_oe_n_o && port_two_o == bus_addr_reg[15:8])
		else $error("port two lost high pc byte");
	data_strobe_a: assert property (!data_write_strobe_n_o
		|-> data_read_strobe_n_o && op_reg == EMFB_OP_DATA_WR)
		else $error("data strobes wrong");
	idle_strobe_a: assert property (state_reg == EMFB_ST_IDLE
		|-> program_store_strobe_n_o && data_read_strobe_n_o
		&& data_write_strobe_n_o)
		else $error("strobe active while idle");

	int_fetch_c: cover property (accept && route_int
		&& req_i.op == EMFB_OP_FETCH);
	ext_fetch_c: cover property (!program_store_strobe_n_o);
	data_wr_c: cover property (!data_write_strobe_n_o && wide_reg);
	data_rd_c: cover property (!data_read_strobe_n_o && !wide_reg);
endmodule : emfb_bus
`default_nettype wire

//--- common/emfb_cfg.svh
// Purpose: constants of the external memory fetch bus
// Assumes: core clock of 100 MHz, one bus state per clock
// Notes:   offsets, rom top addresses, reset values and cycle counts only
`ifndef EMFB_CFG_SVH
`define EMFB_CFG_SVH

`define EMFB_RESET_PC     16'h0000
`define EMFB_VEC_BASE     16'h0003
`define EMFB_VEC_SHIFT    3
`define EMFB_ROM4K_TOP    16'h0fff
`define EMFB_ROM8K_TOP    16'h1fff
`define EMFB_ROM16K_TOP   16'h3fff
`define EMFB_ROM32K_TOP   16'h7fff
`define EMFB_ADDR_CYC     3'h2
`define EMFB_STROBE_CYC   3'h4
`define EMFB_SETTLE_CYC   2'h3
`define EMFB_STROBE_IDLE  1'b1

`endif

//--- common/emfb_pkg.sv
// Purpose: types shared by the external memory fetch bus
// Assumes: nothing beyond the cfg header
// Notes:   requests and answers travel as packed structs
package emfb_pkg;

	typedef enum logic [2:0] {
		EMFB_OP_FETCH,
		EMFB_OP_JUMP,
		EMFB_OP_VECTOR,
		EMFB_OP_CODE_RD,
		EMFB_OP_DATA_RD,
		EMFB_OP_DATA_WR
	} emfb_op_t;

	typedef struct packed {
		logic        valid;
		emfb_op_t    op;
		logic        wide;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} emfb_req_t;

	typedef struct packed {
		logic       valid;
		logic       internal;
		logic [7:0] data;
	} emfb_rsp_t;

	typedef struct packed {
		logic       drive_n;
		logic [7:0] value;
	} emfb_gpio_t;

	typedef enum logic [2:0] {
		EMFB_ST_IDLE,
		EMFB_ST_INT,
		EMFB_ST_ADDR,
		EMFB_ST_HOLD,
		EMFB_ST_STROBE,
		EMFB_ST_END
	} emfb_state_t;

endpackage : emfb_pkg

//--- rtl/emfb_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: input is asynchronous to clock_i
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module emfb_sync #(
	parameter int unsigned          W         = 8,
	parameter logic        [W-1:0]  RESET_VAL = '0
) (
	// clock and reset
	input  wire logic          clock_i,
	input  wire logic          rst_i,
	// data
	input  wire logic [W-1:0]  async_i,
	output logic      [W-1:0]  sync_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			meta_reg <= RESET_VAL;
			sync_o   <= RESET_VAL;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule : emfb_sync
`default_nettype wire

//--- rtl/emfb_route.sv
// Purpose: internal or external choice for a program address
// Assumes: strap already synchronised
// Notes:   ROM_KB of 0 models a romless part
`timescale 1ns/10ps
`default_nettype none
`include "emfb_cfg.svh"
module emfb_route #(
	parameter int unsigned ROM_KB = 4
) (
	// address and strap
	input  wire logic [15:0] addr_i,
	input  wire logic        strap_high_i,
	// decision
	output logic             internal_o
);
	function automatic logic [16:0] rom_top(input int unsigned kb);
		logic [16:0] top;
		top = 17'h00000;
		case (kb)
			4:  top = {1'b1, `EMFB_ROM4K_TOP};
			8:  top = {1'b1, `EMFB_ROM8K_TOP};
			16: top = {1'b1, `EMFB_ROM16K_TOP};
			32: top = {1'b1, `EMFB_ROM32K_TOP};
			default: top = 17'h00000;
		endcase
		return top;
	endfunction : rom_top

	localparam logic [16:0] TOP = rom_top(ROM_KB);

	// bit 16 of TOP says a rom exists; low strap forces everything out
	assign internal_o = strap_high_i && TOP[16] && (addr_i <= TOP[15:0]);
endmodule : emfb_route
`default_nettype wire

//--- test/emfb_mem_model.sv
// Purpose: external code rom, data ram and address latch
// Assumes: the bench resolves the port zero pin
// Notes:   slow_i answers one cycle late; released bus toggles
`timescale 1ns/10ps
`default_nettype none
module emfb_mem_model (
	// clock
	input  wire logic        clock_i,
	// bus pins
	input  wire logic [7:0]  p0_i,
	input  wire logic [7:0]  p2_i,
	input  wire logic        ale_i,
	input  wire logic        pss_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	// behaviour
	input  wire logic        slow_i,
	output logic      [7:0]  p0_o,
	output logic      [15:0] addr_o
);
	logic [7:0]  lat_reg;
	logic [7:0]  held_reg;
	logic        late_reg;
	logic        rd_act;
	logic [15:0] addr;
	logic [7:0]  ram [65536];

	assign addr = {p2_i, lat_reg};
	assign rd_act = !pss_n_i || !rd_n_i;

	always @(negedge ale_i)
		lat_reg <= p0_i;

	always @(posedge clock_i) begin
		held_reg <= p0_i;
		late_reg <= rd_act;
		if (rd_act || !wr_n_i)
			addr_o <= addr;
		if (!wr_n_i)
			ram[addr] <= p0_i;
	end

	// code and data are separate spaces; a released bus shows no stale byte
	always_comb begin
		if (rd_act && (late_reg || !slow_i))
			p0_o = pss_n_i ? ram[addr] : addr[7:0] ^ p2_i ^ 8'h96;
		else
			p0_o = ~held_reg;
	end
endmodule : emfb_mem_model
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench of emfb_bus
// Assumes: rom variants 4 K main, 8/16/32 K and romless probes
// Notes:   internal rom byte is ~addr low xor addr high
`timescale 1ns/10ps
`default_nettype none
module tb;
	import emfb_pkg::*;
	localparam int unsigned KB_TAB [4] = '{8, 16, 32, 0};
	logic        clk, rst, rdy, rom_rd, strap, slow, narrow;
	logic        p0_oe_n, p2_oe_n, ale, pss_n, drd_n, dwr_n;
	logic        saw_pss, saw_rd, saw_wr;
	logic [3:0]  vrdy, vint;
	logic [7:0]  rom_data, p0_o, p0_pin, m_p0, p2_o, cur_wd;
	logic [15:0] pc, rom_addr, m_addr;
	emfb_req_t   req, vreq;
	emfb_rsp_t   rsp, got;
	emfb_rsp_t   vrsp [4];
	emfb_gpio_t  gpio;
	int          bad_count, n_checks;

	assign rom_data = ~rom_addr[7:0] ^ rom_addr[15:8];
	assign p0_pin = p0_oe_n ? m_p0 : p0_o;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	emfb_bus #(.ROM_KB(4)) i_dut (
		.clock_i(clk), .rst_i(rst), .req_i(req), .req_ready_o(rdy),
		.rsp_o(rsp), .pc_o(pc), .gpio_two_i(gpio),
		.int_rom_addr_o(rom_addr), .int_rom_rd_o(rom_rd),
		.int_rom_data_i(rom_data), .external_access_strap_n_i(strap),
		.port_zero_i(p0_pin), .port_zero_o(p0_o),
		.port_zero_oe_n_o(p0_oe_n), .port_two_o(p2_o),
		.port_two_oe_n_o(p2_oe_n), .addr_latch_o(ale),
		.program_store_strobe_n_o(pss_n),
		.data_read_strobe_n_o(drd_n), .data_write_strobe_n_o(dwr_n));

	emfb_mem_model i_mem (
		.clock_i(clk), .p0_i(p0_pin), .p2_i(p2_o), .ale_i(ale),
		.pss_n_i(pss_n), .rd_n_i(drd_n), .wr_n_i(dwr_n),
		.slow_i(slow), .p0_o(m_p0), .addr_o(m_addr));

	for (genvar g = 0; g < 4; g++) begin : g_var
		emfb_bus #(.ROM_KB(KB_TAB[g])) i_var (
			.clock_i(clk), .rst_i(rst), .req_i(vreq),
			.req_ready_o(vrdy[g]), .rsp_o(vrsp[g]), .pc_o(),
			.gpio_two_i(gpio), .int_rom_addr_o(), .int_rom_rd_o(),
			.int_rom_data_i(8'h00), .external_access_strap_n_i(strap),
			.port_zero_i(p0_pin), .port_zero_o(), .port_zero_oe_n_o(),
			.port_two_o(), .port_two_oe_n_o(), .addr_latch_o(),
			.program_store_strobe_n_o(), .data_read_strobe_n_o(),
			.data_write_strobe_n_o());
	end

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic step;
		@(posedge clk);
		#1;
	endtask : step

	// pins are sampled mid-cycle, away from the register updates
	always @(negedge clk) begin
		for (int g = 0; g < 4; g++)
			if (vrsp[g].valid === 1'b1)
				vint[g] = vrsp[g].internal;
		if (!rst && pss_n === 1'b0) begin
			saw_pss = 1'b1;
			chk("bus owned", 3'b010, {p2_oe_n, p0_oe_n, rom_rd});
		end
		if (!rst && ale === 1'b1)
			chk("addr phase", 1'b0, p0_oe_n);
		if (!rst && rom_rd === 1'b1)
			chk("rom quiet", 2'b11, {pss_n, p0_oe_n});
		if (!rst && drd_n === 1'b0) begin
			saw_rd = 1'b1;
			chk("read alone", 2'b11, {pss_n, dwr_n});
			if (narrow)
				chk("page on p2", 8'h3c, p2_o);
		end
		if (!rst && dwr_n === 1'b0) begin
			saw_wr = 1'b1;
			chk("write drive", {1'b0, cur_wd}, {p0_oe_n, p0_o});
		end
	end

	task automatic do_req(input emfb_op_t op, input logic [15:0] a,
		input logic w, input logic [7:0] wd);
		int n;
		n = 0;
		{saw_pss, saw_rd, saw_wr} = 3'b000;
		cur_wd = wd;
		narrow = !w && (op == EMFB_OP_DATA_RD || op == EMFB_OP_DATA_WR);
		req = '{1'b1, op, w, a, wd};
		while (rdy !== 1'b1 && n < 50) begin
			step();
			n++;
		end
		step();
		req.valid = 1'b0;
		while (rsp.valid !== 1'b1 && n < 100) begin
			step();
			n++;
		end
		got = rsp;
		chk("answer", 1'b1, n < 100);
		chk("strobes idle", 3'b111, {pss_n, drd_n, dwr_n});
	endtask : do_req

	task automatic t_reset;
		rst = 1'b1;
		repeat (2) step();
		chk("reset pc", 16'h0000, pc);
		chk("reset pins", 7'h73, {pss_n, drd_n, dwr_n, ale, rdy, p0_oe_n,
			p2_oe_n});
		rst = 1'b0;
	endtask : t_reset

	task automatic t_boot_split;
		do_req(EMFB_OP_FETCH, 16'h0000, 1'b0, 8'h00);
		chk("boot", {2'b10, 8'hff}, {got.internal, saw_pss, got.data});
		for (int n = 0; n < 5; n++) begin
			do_req(EMFB_OP_VECTOR, 16'(n), 1'b0, 8'h00);
			chk("vector", 16'h0003 + 16'(8 * n), pc);
		end
		do_req(EMFB_OP_JUMP, 16'h0fff, 1'b0, 8'h00);
		do_req(EMFB_OP_FETCH, 16'h0000, 1'b0, 8'h00);
		chk("rom top", {2'b10, 8'h0f}, {got.internal, saw_pss, got.data});
		do_req(EMFB_OP_FETCH, 16'h0000, 1'b0, 8'h00);
		chk("ext first", {2'b01, 8'h86}, {got.internal, saw_pss, got.data});
		chk("latched", 16'h1000, m_addr);
		slow = 1'b1;
		do_req(EMFB_OP_CODE_RD, 16'hffff, 1'b0, 8'h00);
		slow = 1'b0;
		chk("slow top", {1'b0, 8'h96}, {got.internal, got.data});
		chk("full addr", 16'hffff, m_addr);
	endtask : t_boot_split

	task automatic t_data;
		do_req(EMFB_OP_DATA_WR, 16'h1234, 1'b1, 8'ha5);
		chk("wr only", 3'b001, {saw_pss, saw_rd, saw_wr});
		chk("wide addr", 16'h1234, m_addr);
		do_req(EMFB_OP_DATA_RD, 16'h1234, 1'b1, 8'h00);
		chk("rd back", {3'b010, 8'ha5}, {saw_pss, saw_rd, saw_wr, got.data});
		do_req(EMFB_OP_CODE_RD, 16'h1234, 1'b0, 8'h00);
		chk("own space", 8'hb0, got.data);
		do_req(EMFB_OP_DATA_WR, 16'h0056, 1'b0, 8'h5c);
		chk("paged addr", 16'h3c56, m_addr);
		do_req(EMFB_OP_DATA_RD, 16'h0056, 1'b0, 8'h00);
		chk("paged rd", 8'h5c, got.data);
	endtask : t_data

	task automatic t_variants;
		logic [15:0] tab [6];
		int          n;
		tab = '{16'h1fff, 16'h2000, 16'h3fff, 16'h4000, 16'h7fff, 16'h8000};
		foreach (tab[i]) begin
			n = 0;
			while (vrdy !== 4'hf && n < 50) begin
				step();
				n++;
			end
			vint = 4'bxxxx;
			vreq = '{1'b1, EMFB_OP_CODE_RD, 1'b0, tab[i], 8'h00};
			step();
			vreq.valid = 1'b0;
			repeat (12) step();
			for (int g = 0; g < 4; g++)
				chk("variant", KB_TAB[g] != 0 && tab[i] < KB_TAB[g] * 1024,
					vint[g]);
		end
	endtask : t_variants

	task automatic t_strap_low;
		strap = 1'b0;
		repeat (4) step();
		do_req(EMFB_OP_CODE_RD, 16'h0123, 1'b0, 8'h00);
		chk("strap low", {2'b01, 8'hb4}, {got.internal, saw_pss, got.data});
		t_reset();
		do_req(EMFB_OP_FETCH, 16'h0000, 1'b0, 8'h00);
		chk("refetch", 16'h0000, m_addr);
	endtask : t_strap_low

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		#50000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		{rst, strap, slow, narrow} = 4'b1100;
		{saw_pss, saw_rd, saw_wr} = 3'b000;
		req = '0;
		vreq = '0;
		gpio = '{1'b0, 8'h3c};
		cur_wd = 8'h00;
		bad_count = 0;
		n_checks = 0;
		t_reset();
		t_variants();
		t_boot_split();
		t_data();
		t_strap_low();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
